// [design/rsc_reset_ctrl.sv]
// Reset source controller: merges reset sources into the master reset,
// keeps the cause register, times release and picks the post-reset clock.
// Assumes all inputs synchronous to clk_i except pin and brown-out requests.
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "rsc_map.svh"
module rsc_reset_ctrl #(
    parameter int PWRT_CYCLES = (`RSC_PWRT_MS * (`RSC_CLK_HZ / 1000)),
    parameter int POR_CYCLES = 16,
    parameter int RST_CYCLES = 16,
    parameter int RC_CYCLES = 16,
    parameter int LOCK_CYCLES = 64,
    parameter int FAILSAFE_CLOCK_MONITOR_CYCLES = 8,
    parameter int CNT_W = 24
) (
    // Clock and power-on reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [1:0] sel_i,
    input wire logic [15:0] dat_i,
    output logic [15:0] dat_o,
    output logic ack_o,
    // Reset request sources.
    input wire logic pin_reset_req_i,
    input wire logic brownout_req_i,
    input wire logic soft_reset_req_i,
    input wire logic wdt_timeout_i,
    input wire logic cfg_mismatch_i,
    input wire logic trap_conflict_i,
    input wire logic illegal_op_i,
    // Power-save and watchdog instruction events.
    input wire logic power_save_instr_sleep_i,
    input wire logic power_save_instr_idle_i,
    input wire logic wdt_clear_i,
    // Configuration and oscillator state.
    input wire logic watchdog_fuse_i,
    input wire logic clk_switch_en_i,
    input wire logic two_speed_en_i,
    input wire logic [2:0] initial_osc_select_i,
    input wire logic [2:0] current_osc_field_i,
    input wire logic osc_tick_i,
    // Reset and clock outputs.
    output logic master_reset_out_o,
    output logic clock_valid_o,
    output logic [2:0] reset_osc_sel_o,
    output logic watchdog_en_o,
    output logic pmem_bias_in_lowpower_o,
    output logic failsafe_clock_monitor_en_o
);
    // Guard against a counter too narrow for the longest delay.
    initial begin
        if (PWRT_CYCLES < 1 || PWRT_CYCLES >= (1 << CNT_W) || RST_CYCLES < 1 ||
            POR_CYCLES < 1 || LOCK_CYCLES >= (1 << CNT_W)) begin
            $error("rsc_reset_ctrl: delay parameters do not fit the counter");
        end
    end

    localparam logic [10:0] OST_COUNT = 11'(`RSC_OST_PERIODS);

    // Synchroniser stages for the asynchronous requests.
    logic [1:0] pin_sync_reg;
    logic [1:0] bor_sync_reg;
    logic pin_meta_reg;
    logic bor_meta_reg;

    // Cause register, sequencer and clock delay state.
    logic [15:0] cause_reg, cause_next;
    rsc_pkg::rsc_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] clk_cnt_reg, clk_cnt_next;
    logic [10:0] ost_reg, ost_next;
    logic clk_ok_reg, clk_ok_next;
    logic [2:0] osc_reg, osc_next;
    logic [CNT_W-1:0] failsafe_clock_monitor_cnt_reg, failsafe_clock_monitor_cnt_next;
    logic failsafe_clock_monitor_reg, failsafe_clock_monitor_next;
    logic ack_reg, ack_next;
    logic [15:0] dat_reg, dat_next;
    // Low only in the first cycle after power-on, when the first source is chosen.
    logic por_osc_loaded_reg;

    // Current synchronised levels.
    logic pin_req;
    logic bor_req;
    logic warm_req;
    assign pin_req = pin_sync_reg[1];
    assign bor_req = bor_sync_reg[1];
    // Any non-power-on source; brown-out restarts the power-up timer, the rest the state timer, but only from the state timer or run state.
    assign warm_req = pin_req | bor_req | soft_reset_req_i | wdt_timeout_i |
                      cfg_mismatch_i | trap_conflict_i | illegal_op_i;

    // Source-dependent clock delay, in cycles.
    function automatic logic [CNT_W-1:0] clk_delay(input logic [2:0] src);
        unique case (src)
            rsc_pkg::RSC_OSC_FRC, rsc_pkg::RSC_OSC_FRCDIV,
            rsc_pkg::RSC_OSC_LPRC: clk_delay = CNT_W'(RC_CYCLES);
            rsc_pkg::RSC_OSC_FRCPLL: clk_delay = CNT_W'(RC_CYCLES + LOCK_CYCLES);
            rsc_pkg::RSC_OSC_PRIPLL: clk_delay = CNT_W'(LOCK_CYCLES);
            default: clk_delay = '0;
        endcase
    endfunction

    // Crystal sources also wait for the start-up timer.
    function automatic logic is_xtal(input logic [2:0] src);
        is_xtal = (src == rsc_pkg::RSC_OSC_PRI) || (src == rsc_pkg::RSC_OSC_PRIPLL) ||
                  (src == rsc_pkg::RSC_OSC_SOSC);
    endfunction

    // Three flip-flops per asynchronous request; each stage feeds only the next.
    always_ff @(posedge clk_i) begin
        pin_meta_reg <= pin_reset_req_i;
        bor_meta_reg <= brownout_req_i;
        pin_sync_reg <= {pin_sync_reg[0], pin_meta_reg};
        bor_sync_reg <= {bor_sync_reg[0], bor_meta_reg};
    end

    // Cause register: hardware sets win over a same-cycle software write.
    always_comb begin
        cause_next = cause_reg;
        if (cyc_i && stb_i && we_i && !ack_reg && adr_i == `RSC_CAUSE_OFS) begin
            // Writes only store; they raise no reset.
            if (sel_i[0]) cause_next[7:0] = dat_i[7:0];
            if (sel_i[1]) cause_next[15:8] = dat_i[15:8];
            cause_next = cause_next & `RSC_CAUSE_MASK;
        end
        if (wdt_clear_i || power_save_instr_sleep_i || power_save_instr_idle_i) begin
            cause_next[`RSC_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
        end
        if (trap_conflict_i) cause_next[`RSC_TRAP_BIT] = 1'b1;
        if (illegal_op_i) cause_next[`RSC_ILLOP_BIT] = 1'b1;
        if (cfg_mismatch_i) cause_next[`RSC_CFGMIS_BIT] = 1'b1;
        if (pin_req) cause_next[`RSC_PIN_BIT] = 1'b1;
        if (soft_reset_req_i) cause_next[`RSC_SOFT_BIT] = 1'b1;
        if (wdt_timeout_i) cause_next[`RSC_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
        if (power_save_instr_sleep_i) cause_next[`RSC_SLEEP_BIT] = 1'b1;
        if (power_save_instr_idle_i) cause_next[`RSC_IDLE_BIT] = 1'b1;
        if (bor_req) cause_next[`RSC_BOR_BIT] = 1'b1;
    end

    // Release sequencer: power-on, power-up timer, then state timer.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            rsc_pkg::RSC_ST_POR: begin
                if (cnt_reg >= CNT_W'(POR_CYCLES - 1)) begin
                    state_next = rsc_pkg::RSC_ST_PWRT;
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            rsc_pkg::RSC_ST_PWRT: begin
                if (cnt_reg >= CNT_W'(PWRT_CYCLES - 1)) begin
                    state_next = rsc_pkg::RSC_ST_RST;
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            rsc_pkg::RSC_ST_RST: begin
                if (cnt_reg >= CNT_W'(RST_CYCLES - 1)) begin
                    state_next = rsc_pkg::RSC_ST_RUN;
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            default: begin
                cnt_next = '0;
            end
        endcase
        // A brown-out restarts at the power-up timer, other sources at the state timer, but only from the state timer or run state.
        if (bor_req) begin
            state_next = rsc_pkg::RSC_ST_PWRT;
            cnt_next = '0;
        end else if (warm_req) begin
            if (state_reg == rsc_pkg::RSC_ST_RUN || state_reg == rsc_pkg::RSC_ST_RST) begin
                state_next = rsc_pkg::RSC_ST_RST;
                cnt_next = '0;
            end
        end
    end

    // Clock source choice and its start-up delay, running beside the reset delay.
    always_comb begin
        osc_next = osc_reg;
        clk_cnt_next = clk_cnt_reg;
        ost_next = ost_reg;
        clk_ok_next = clk_ok_reg;
        if (!por_osc_loaded_reg) begin
            // Power-on: two-speed start runs on the fast RC, else on the configured source.
            if (two_speed_en_i) begin
                osc_next = rsc_pkg::RSC_OSC_FRC;
            end else begin
                osc_next = initial_osc_select_i;
            end
            clk_cnt_next = '0;
            ost_next = '0;
            clk_ok_next = 1'b0;
        end else if (bor_req || (warm_req && state_reg == rsc_pkg::RSC_ST_RUN)) begin
            // Switching enabled: warm resets other than brown-out keep the running source.
            if (clk_switch_en_i && !bor_req) begin
                osc_next = current_osc_field_i;
            end else begin
                osc_next = initial_osc_select_i;
            end
            clk_cnt_next = '0;
            ost_next = '0;
            clk_ok_next = 1'b0;
        end else if (!clk_ok_reg) begin
            if (clk_cnt_reg < clk_delay(osc_reg)) begin
                clk_cnt_next = clk_cnt_reg + 1'b1;
            end
            if (is_xtal(osc_reg) && osc_tick_i && ost_reg < OST_COUNT) begin
                ost_next = ost_reg + 1'b1;
            end
            if (clk_cnt_reg >= clk_delay(osc_reg) &&
                (!is_xtal(osc_reg) || ost_reg >= OST_COUNT)) begin
                clk_ok_next = 1'b1;
            end
        end
    end

    // Clock monitor start waits a fixed delay after reset release.
    always_comb begin
        failsafe_clock_monitor_cnt_next = failsafe_clock_monitor_cnt_reg;
        failsafe_clock_monitor_next = failsafe_clock_monitor_reg;
        if (state_reg != rsc_pkg::RSC_ST_RUN) begin
            failsafe_clock_monitor_cnt_next = '0;
            failsafe_clock_monitor_next = 1'b0;
        end else if (!failsafe_clock_monitor_reg) begin
            if (failsafe_clock_monitor_cnt_reg >= CNT_W'(FAILSAFE_CLOCK_MONITOR_CYCLES - 1)) begin
                failsafe_clock_monitor_next = 1'b1;
            end else begin
                failsafe_clock_monitor_cnt_next = failsafe_clock_monitor_cnt_reg + 1'b1;
            end
        end
    end

    // Wishbone answer: one-cycle ack, zero for unmapped reads.
    always_comb begin
        ack_next = cyc_i && stb_i && !ack_reg;
        dat_next = dat_reg;
        if (cyc_i && stb_i && !ack_reg && !we_i) begin
            unique case (adr_i)
                `RSC_CAUSE_OFS: dat_next = cause_reg;
                `RSC_STATUS_OFS: dat_next = {12'h000, failsafe_clock_monitor_reg, clk_ok_reg,
                                             state_reg == rsc_pkg::RSC_ST_RUN, 1'b0};
                default: dat_next = 16'h0000;
            endcase
        end
    end

    // State registers; the power-on reset loads constants only.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_reg <= `RSC_CAUSE_POR;
            state_reg <= rsc_pkg::RSC_ST_POR;
            cnt_reg <= '0;
            clk_cnt_reg <= '0;
            ost_reg <= '0;
            clk_ok_reg <= 1'b0;
            osc_reg <= rsc_pkg::RSC_OSC_FRC;
            failsafe_clock_monitor_cnt_reg <= '0;
            failsafe_clock_monitor_reg <= 1'b0;
            ack_reg <= 1'b0;
            dat_reg <= 16'h0000;
        end else begin
            cause_reg <= cause_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            clk_cnt_reg <= clk_cnt_next;
            ost_reg <= ost_next;
            clk_ok_reg <= clk_ok_next;
            osc_reg <= osc_next;
            failsafe_clock_monitor_cnt_reg <= failsafe_clock_monitor_cnt_next;
            failsafe_clock_monitor_reg <= failsafe_clock_monitor_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    // Marks that the power-on source choice has been made.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_osc_loaded_reg <= 1'b0;
        end else begin
            por_osc_loaded_reg <= 1'b1;
        end
    end

    // Outputs.
    assign master_reset_out_o = (state_reg != rsc_pkg::RSC_ST_RUN) | warm_req;
    // A fresh warm request withdraws the clock at once, together with master reset.
    assign clock_valid_o = clk_ok_reg & (state_reg == rsc_pkg::RSC_ST_RUN) & !warm_req;
    assign reset_osc_sel_o = osc_reg;
    assign watchdog_en_o = watchdog_fuse_i | cause_reg[`RSC_WDEN_BIT];
    assign pmem_bias_in_lowpower_o = cause_reg[`RSC_PMBIAS_BIT];
    assign failsafe_clock_monitor_en_o = failsafe_clock_monitor_reg;
    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
endmodule // rsc_reset_ctrl

// [design/rsc_map.svh]
// Register map, field positions, reset values and timing counts of the
// reset source controller. Assumes the including file is compiled once per unit.
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
// Register byte offsets on the Wishbone bus.
`define RSC_CAUSE_OFS 8'h00
`define RSC_STATUS_OFS 8'h04
// Field positions in the reset cause and control register.
`define RSC_TRAP_BIT 15
`define RSC_ILLOP_BIT 14
`define RSC_CFGMIS_BIT 9
`define RSC_PMBIAS_BIT 8
`define RSC_PIN_BIT 7
`define RSC_SOFT_BIT 6
`define RSC_WDEN_BIT 5
`define RSC_WATCHDOG_TIMEOUT_FLAG_BIT 4
`define RSC_SLEEP_BIT 3
`define RSC_IDLE_BIT 2
`define RSC_BOR_BIT 1
`define RSC_POR_BIT 0
// Writable bits and value taken at power-on.
`define RSC_CAUSE_MASK 16'hC3FF
`define RSC_CAUSE_POR 16'h0003
// Timing figures in their own units.
`define RSC_CLK_HZ 10000000
`define RSC_PWRT_MS 64
`define RSC_OST_PERIODS 1024
`endif

// [design/rsc_pkg.sv]
// Types shared by the reset source controller.
// Assumes the map header supplies all numeric constants.
package rsc_pkg;
    // Reset release sequencer states.
    typedef enum logic [2:0] {
        RSC_ST_POR = 3'b000,
        RSC_ST_PWRT = 3'b001,
        RSC_ST_RST = 3'b010,
        RSC_ST_RUN = 3'b011
    } rsc_state_t;
    // Oscillator source codes as held in the select fields.
    typedef enum logic [2:0] {
        RSC_OSC_FRC = 3'b000,
        RSC_OSC_FRCPLL = 3'b001,
        RSC_OSC_PRI = 3'b010,
        RSC_OSC_PRIPLL = 3'b011,
        RSC_OSC_SOSC = 3'b100,
        RSC_OSC_LPRC = 3'b101,
        RSC_OSC_RSV = 3'b110,
        RSC_OSC_FRCDIV = 3'b111
    } rsc_osc_t;
endpackage

// [bench/rsc_reset_ctrl_properties.sv]
// Port checker for the reset source controller.
// Assumes one clock and a synchronous active-high power-on reset.
`timescale 1ns/1ps
module rsc_reset_ctrl_properties (
    // Clock, reset and bus.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [1:0] sel_i,
    input wire logic [15:0] dat_i,
    input wire logic ack_o,
    // Sources and outputs watched.
    input wire logic soft_reset_req_i,
    input wire logic wdt_timeout_i,
    input wire logic trap_conflict_i,
    input wire logic pin_reset_req_i,
    input wire logic watchdog_fuse_i,
    input wire logic master_reset_out_o,
    input wire logic clock_valid_o,
    input wire logic watchdog_en_o,
    input wire logic pmem_bias_in_lowpower_o,
    input wire logic failsafe_clock_monitor_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A request the slave has not yet answered.
    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    // A write that reaches the upper byte of the cause register.
    sequence s_wr_hi; s_req ##0 (we_i && adr_i == 8'h00 && sel_i[1]); endsequence
    a_ack_reply: assert property (s_req |=> ack_o)
        else $error("bus request not answered next cycle");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_sync_src: assert property ((soft_reset_req_i || wdt_timeout_i || trap_conflict_i)
        |-> master_reset_out_o)
        else $error("reset source active without master reset");
    a_pin_sync: assert property ($rose(pin_reset_req_i) |-> ##[1:4] master_reset_out_o)
        else $error("pin request did not reach master reset");
    a_por_start: assert property ($past(rst_i) |-> master_reset_out_o)
        else $error("master reset low right after power-on");
    a_fuse_wden: assert property (watchdog_fuse_i |-> watchdog_en_o)
        else $error("watchdog off while fuse set");
    a_clk_hold: assert property (master_reset_out_o |-> !clock_valid_o)
        else $error("clock valid during reset");
    a_failsafe_clock_monitor_delay: assert property ($fell(master_reset_out_o)
        |-> !failsafe_clock_monitor_en_o [*7])
        else $error("clock monitor started too early");
    a_pmbias_wr: assert property (s_wr_hi |=> ##1
        (pmem_bias_in_lowpower_o == $past(dat_i[8], 2)))
        else $error("bias bit not taken from write");
endmodule // rsc_reset_ctrl_properties
bind rsc_reset_ctrl rsc_reset_ctrl_properties rsc_reset_ctrl_properties_inst (.*);

// [bench/rsc_src_model.sv]
// Far-side model: reset sources held four cycles, and an oscillator tick.
// Assumes kind_i stays put while a request is held.
`timescale 1ns/1ps
module rsc_src_model (
    // Clock and command from the bench.
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [2:0] kind_i,
    // Source lines and oscillator periods.
    output logic [6:0] req_o,
    output logic osc_tick_o
);
    logic [2:0] hold_reg = 3'h0; // Cycles the request still stands.
    initial osc_tick_o = 1'b0;
    // Four cycles are enough for the pin synchroniser to see the level.
    always @(posedge clk_i) begin
        osc_tick_o <= !osc_tick_o;
        if (start_i) hold_reg <= 3'h4;
        else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
    end
    assign req_o = (hold_reg != 3'h0) ? (7'h01 << kind_i) : 7'h00;
endmodule // rsc_src_model

// [bench/rsc_reset_ctrl_bench.sv]
// Self-checking bench of the reset source controller over Wishbone.
// Assumes PWRT_CYCLES of 20 and the other counts at their defaults.
`timescale 1ns/1ps
module rsc_reset_ctrl_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [15:0] dat_i = 16'h0000, dat_o, rd, exp;
    logic ack_o, mrst, cvalid, wden, pmb, failsafe_clock_monitor, tick, start = 1'b0;
    logic fuse = 1'b0, sw = 1'b1, two = 1'b0;
    logic [2:0] ps = 3'h0, osc, kind = 3'h0;
    logic [6:0] req;
    int err_total = 0, tests_run = 0, n;
    // Bit of the cause register set by each source kind.
    int bitpos [7] = '{6, 4, 9, 15, 14, 7, 1};
    always #50 clk_i = ~clk_i;
    rsc_src_model rsc_src_model_inst (.clk_i(clk_i), .start_i(start), .kind_i(kind),
        .req_o(req), .osc_tick_o(tick));
    rsc_reset_ctrl #(.PWRT_CYCLES(20)) rsc_reset_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(2'h3),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_reset_req_i(req[5]),
        .brownout_req_i(req[6]), .soft_reset_req_i(req[0]), .wdt_timeout_i(req[1]),
        .cfg_mismatch_i(req[2]), .trap_conflict_i(req[3]), .illegal_op_i(req[4]),
        .power_save_instr_sleep_i(ps[0]), .power_save_instr_idle_i(ps[1]), .wdt_clear_i(ps[2]),
        .watchdog_fuse_i(fuse), .clk_switch_en_i(sw), .two_speed_en_i(two),
        .initial_osc_select_i(3'b010), .current_osc_field_i(3'b001), .osc_tick_i(tick),
        .master_reset_out_o(mrst), .clock_valid_o(cvalid), .reset_osc_sel_o(osc),
        .watchdog_en_o(wden), .pmem_bias_in_lowpower_o(pmb),
        .failsafe_clock_monitor_en_o(failsafe_clock_monitor));
    // Counts every comparison and reports a mismatch at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            err_total++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // One classic cycle; read data is taken at the edge that sees ack.
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
        if (n == 50) err_total++;
    endtask
    // Waits for release and a valid clock, with a bound.
    task automatic settle();
        repeat (8) @(posedge clk_i);
        n = 0;
        while (!(mrst === 1'b0 && cvalid === 1'b1) && n < 4000) begin
            @(negedge clk_i); n++;
        end
        check(16'(n < 4000), 16'h0001);
    endtask
    task automatic por();
        @(posedge clk_i); rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        n = 0;
        while (mrst !== 1'b0 && n < 200) begin @(negedge clk_i); n++; end
        check(16'(n > 50 && n < 56), 16'h0001);
        settle();
        wb(1'b0, 8'h00, 16'h0000); check(rd, 16'h0003);
    endtask
    task automatic fire(input logic [2:0] k);
        @(posedge clk_i); kind <= k; start <= 1'b1;
        @(posedge clk_i); start <= 1'b0;
        settle();
    endtask
    // Power-save and watchdog-clear pulse, then a read of the flags.
    task automatic ev(input logic [2:0] v);
        @(posedge clk_i); ps <= v;
        @(posedge clk_i); ps <= 3'h0;
        wb(1'b0, 8'h00, 16'h0000); check(rd, exp);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #(30000 * 100);
        err_total++;
        results();
    end
    initial begin
        por();
        check(16'(osc), 16'h0002);
        wb(1'b0, 8'h08, 16'h0000); check(rd, 16'h0000);
        wb(1'b1, 8'h00, 16'hFFFF); wb(1'b0, 8'h00, 16'h0000); check(rd, 16'hC3FF);
        check(16'({mrst, wden, pmb}), 16'h0003);
        wb(1'b1, 8'h00, 16'h0000); check(16'({wden, pmb}), 16'h0000);
        @(posedge clk_i); fuse <= 1'b1;
        @(negedge clk_i); check(16'(wden), 16'h0001);
        fuse <= 1'b0;
        exp = 16'h0000;
        for (int k = 0; k < 7; k++) begin
            fire(3'(k));
            exp[bitpos[k]] = 1'b1;
            wb(1'b0, 8'h00, 16'h0000); check(rd, exp);
            if (k < 2 || k == 5) check(16'(osc), 16'h0001);
            if (k == 6) check(16'(osc), 16'h0002);
        end
        exp[4] = 1'b0; ev(3'h4);
        fire(3'h1); exp[4] = 1'b0; exp[3] = 1'b1; ev(3'h1);
        exp[2] = 1'b1; ev(3'h2);
        @(posedge clk_i); sw <= 1'b0;
        fire(3'h0); check(16'(osc), 16'h0002);
        @(posedge clk_i); two <= 1'b1; sw <= 1'b1;
        por(); check(16'(osc), 16'h0000);
        results();
    end
endmodule // rsc_reset_ctrl_bench
